// file: design/csf_clock_switch.sv
// Contract
// RL1: A clock loss seen by the fail-safe monitor sets the clock-fail flag, which reads zero otherwise; the code also sets it on a software write of one.
// RL2: Software should only clear the clock-fail flag and not write a one to it in normal use.
// RL3: Writing a one to the clock-fail flag acts like a real failure, including the oscillator failure trap.
// RL4: Writing one to the switch request asks for a change of system clock to the next-source selection.
// RL5: The switch request bit returns to zero when the switch has finished, so software can poll it.
// RL6: Writes to the oscillator control register take effect only after an unlock sequence, before every write.
// RL7: Software must not switch directly between a primary PLL mode and the RC PLL mode, but go via plain RC.
// RL8: Bits 4, 2 and 1 of the control register always read as zero.
// RL9: The fail-safe monitor detects a lost clock so the application can recover or shut down.
// RL10: The unlock is a one-shot permission armed by two key writes; a write without it changes nothing.
`timescale 1ns/10ps
`default_nettype none
`include "csf_consts.svh"
module csf_clock_switch #(
    parameter int unsigned ADDR_W = 8,
    parameter int unsigned FAIL_TIMEOUT = `CSF_FAIL_TIMEOUT_CYC,
    parameter int unsigned SETTLE = `CSF_SETTLE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_tick,
    input wire logic monitor_enable,
    output logic [2:0] source_select,
    output logic switch_active,
    output logic osc_fail_trap,
    output logic irq
);
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
        $error("csf_clock_switch: ADDR_W must lie between 5 and 32");
    end

    function automatic csf_pkg::csf_reg_t reg_decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] a;
        a = {addr[ADDR_W-1:2], 2'b00};
        if (a == ADDR_W'(`CSF_OFF_CTRL)) return csf_pkg::CSF_REG_CTRL;
        else if (a == ADDR_W'(`CSF_OFF_UNLOCK)) return csf_pkg::CSF_REG_UNLOCK;
        else if (a == ADDR_W'(`CSF_OFF_STATUS)) return csf_pkg::CSF_REG_STATUS;
        else if (a == ADDR_W'(`CSF_OFF_MASK)) return csf_pkg::CSF_REG_MASK;
        else return csf_pkg::CSF_REG_NONE;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                            input logic [1:0] strb);
        return {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    logic aw_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    csf_pkg::csf_reg_t wr_sel;
    csf_pkg::csf_reg_t rd_sel;
    csf_pkg::csf_unlock_t ul_q;
    csf_pkg::csf_src_t nosc_q;
    logic cf_q;
    logic start_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic rd_ctrl_q;
    logic [15:0] ctrl_value;
    logic [15:0] ctrl_new;
    logic ctrl_wr;
    logic ctrl_wr_ok;
    logic cf_set_now;
    logic fail_pulse;
    logic busy;
    logic done_pulse;

    // Write channel capture, both orders accepted
    assign s_axi_awready = ce && !aw_have_q;
    assign s_axi_wready = ce && !w_have_q;
    assign wr_fire = ce && aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_sel = reg_decode(aw_addr_q);
    assign ctrl_wr = wr_fire && (wr_sel == csf_pkg::CSF_REG_CTRL);
    assign ctrl_wr_ok = ctrl_wr && (ul_q == csf_pkg::CSF_UL_ARMED); // [RL6]
    assign ctrl_new = merge16(ctrl_value, w_data_q[15:0], w_strb_q[1:0]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSF_RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == csf_pkg::CSF_REG_NONE) ? `CSF_RESP_SLVERR : `CSF_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Unlock guard: two key writes arm one control write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ul_q <= csf_pkg::CSF_UL_LOCKED;
        end else if (ce) begin
            if (ctrl_wr) begin
                ul_q <= csf_pkg::CSF_UL_LOCKED; // [RL10]
            end else if (wr_fire && wr_sel == csf_pkg::CSF_REG_UNLOCK) begin
                if (w_strb_q[1:0] != 2'h3) begin
                    ul_q <= csf_pkg::CSF_UL_LOCKED;
                end else if (ul_q == csf_pkg::CSF_UL_KEY1 && w_data_q[15:0] == `CSF_KEY2) begin
                    ul_q <= csf_pkg::CSF_UL_ARMED; // [RL10]
                end else if (w_data_q[15:0] == `CSF_KEY1) begin
                    ul_q <= csf_pkg::CSF_UL_KEY1;
                end else begin
                    ul_q <= csf_pkg::CSF_UL_LOCKED;
                end
            end
        end
    end

    // A new failure, from the monitor or from software
    assign cf_set_now = fail_pulse || (ctrl_wr_ok && ctrl_new[`CSF_BIT_CF] && !cf_q); // [RL3]

    // Next-source selection and switch request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nosc_q <= `CSF_SRC_RC;
            start_q <= 1'b0;
        end else if (ce) begin
            start_q <= 1'b0;
            if (ctrl_wr_ok) begin
                nosc_q <= ctrl_new[`CSF_NEXT_LSB +: 3];
                if (ctrl_new[`CSF_BIT_SWREQ] && !busy && !start_q && !cf_set_now) begin
                    start_q <= 1'b1; // [RL4]
                end
            end
        end
    end

    // Clock-fail flag; a hardware set wins over a clearing write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cf_q <= 1'b0;
        end else if (ce) begin
            if (fail_pulse) begin
                cf_q <= 1'b1; // [RL1]
            end else if (ctrl_wr_ok) begin
                cf_q <= ctrl_new[`CSF_BIT_CF]; // [RL3]
            end
        end
    end

    // Interrupt status, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= `CSF_IRQ_RST;
            mask_q <= `CSF_IRQ_RST;
        end else if (ce) begin
            status_q <= (status_q & ~((wr_fire && wr_sel == csf_pkg::CSF_REG_STATUS && w_strb_q[0])
                        ? w_data_q[1:0] : 2'h0)) | {cf_set_now, done_pulse};
            if (wr_fire && wr_sel == csf_pkg::CSF_REG_MASK && w_strb_q[0]) begin
                mask_q <= w_data_q[1:0];
            end
        end
    end

    assign irq = |(status_q & mask_q);
    assign osc_fail_trap = cf_q; // [RL3]
    assign switch_active = busy;

    // Control register view; unimplemented bits stay zero
    always_comb begin
        ctrl_value = `CSF_CTRL_RST;
        ctrl_value[`CSF_CUR_LSB +: 3] = source_select;
        ctrl_value[`CSF_NEXT_LSB +: 3] = nosc_q;
        ctrl_value[`CSF_BIT_CF] = cf_q; // [RL1]
        ctrl_value[`CSF_BIT_SWREQ] = start_q || busy; // [RL5]
    end

    // Read channel
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign rd_sel = reg_decode(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `CSF_RESP_OKAY;
            rd_ctrl_q <= 1'b0;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                rd_ctrl_q <= (rd_sel == csf_pkg::CSF_REG_CTRL);
                s_axi_rresp <= (rd_sel == csf_pkg::CSF_REG_NONE) ? `CSF_RESP_SLVERR : `CSF_RESP_OKAY;
                case (rd_sel)
                    csf_pkg::CSF_REG_CTRL: s_axi_rdata <= {16'h0000, ctrl_value}; // [RL8]
                    csf_pkg::CSF_REG_UNLOCK: s_axi_rdata <= {31'h0, ul_q == csf_pkg::CSF_UL_ARMED};
                    csf_pkg::CSF_REG_STATUS: s_axi_rdata <= {30'h0, status_q};
                    csf_pkg::CSF_REG_MASK: s_axi_rdata <= {30'h0, mask_q};
                    default: s_axi_rdata <= '0;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    csf_fail_monitor #(
        .TIMEOUT(FAIL_TIMEOUT)
    ) u_monitor (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .enable(monitor_enable),
        .src_tick(osc_tick),
        .fail_pulse(fail_pulse)
    );

    csf_switch_seq #(
        .SETTLE(SETTLE)
    ) u_switch (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .start(start_q),
        .target(nosc_q),
        .abort(cf_set_now),
        .busy(busy),
        .done_pulse(done_pulse),
        .cur_src(source_select)
    );

    AST_CF_SET: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
        ce && fail_pulse |=> cf_q && osc_fail_trap && source_select == `CSF_SRC_RC && status_q[`CSF_IRQ_FAIL])
        else $error("Clock loss did not set the fail flag");

    AST_SW_TRAP: assert property (@(posedge aclk) disable iff (!aresetn) // [RL3]
        ctrl_wr_ok && ctrl_new[`CSF_BIT_CF] && !cf_q |=> osc_fail_trap && source_select == `CSF_SRC_RC
        && status_q[`CSF_IRQ_FAIL])
        else $error("Software fail write did not raise the trap");

    AST_CF_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
        !fail_pulse && !ctrl_wr_ok |=> $stable(cf_q))
        else $error("Clock-fail flag changed with no failure and no write");

    AST_START_BUSY: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
        ce && start_q && !cf_set_now |=> busy)
        else $error("Switch request did not start the switch");

    AST_SWREQ_DONE: assert property (@(posedge aclk) disable iff (!aresetn) // [RL5]
        done_pulse |-> ctrl_value[`CSF_BIT_SWREQ] == 1'b0)
        else $error("Switch request bit still set after the switch");

    AST_LOCKED_WRITE: assert property (@(posedge aclk) disable iff (!aresetn) // [RL6]
        ctrl_wr && ul_q != csf_pkg::CSF_UL_ARMED && !fail_pulse |=> $stable(nosc_q) && $stable(cf_q) && !start_q)
        else $error("Locked control write changed the register");

    AST_ONE_SHOT: assert property (@(posedge aclk) disable iff (!aresetn) // [RL10]
        ctrl_wr ##1 (!wr_fire || wr_sel != csf_pkg::CSF_REG_UNLOCK) [*2] |-> ul_q != csf_pkg::CSF_UL_ARMED)
        else $error("Unlock permission survived a control write");

    AST_RSVD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
        s_axi_rvalid && rd_ctrl_q |-> s_axi_rdata[4] == 1'b0 && s_axi_rdata[2:1] == 2'h0)
        else $error("Unimplemented control bits read nonzero");
endmodule
`default_nettype wire

// file: design/csf_consts.svh
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH

// Register byte offsets
`define CSF_OFF_CTRL 8'h00
`define CSF_OFF_UNLOCK 8'h04
`define CSF_OFF_STATUS 8'h08
`define CSF_OFF_MASK 8'h0c

// Control register fields
`define CSF_BIT_SWREQ 0
`define CSF_BIT_CF 3
`define CSF_NEXT_LSB 8
`define CSF_CUR_LSB 12
`define CSF_CTRL_RST 16'h0000

// Clock source code of the internal RC source
`define CSF_SRC_RC 3'h0

// Unlock keys, arbitrary values
`define CSF_KEY1 16'h5a5a
`define CSF_KEY2 16'ha5a5

// Interrupt status bits
`define CSF_IRQ_SWDONE 0
`define CSF_IRQ_FAIL 1
`define CSF_IRQ_RST 2'h0

// AXI responses
`define CSF_RESP_OKAY 2'h0
`define CSF_RESP_SLVERR 2'h2

// Timing
`define CSF_CLK_PERIOD_NS 10
`define CSF_FAIL_TIMEOUT_NS 2000
`define CSF_FAIL_TIMEOUT_CYC (`CSF_FAIL_TIMEOUT_NS / `CSF_CLK_PERIOD_NS)
`define CSF_SETTLE_NS 500
`define CSF_SETTLE_CYC ((`CSF_SETTLE_NS + `CSF_CLK_PERIOD_NS - 1) / `CSF_CLK_PERIOD_NS)

`endif

// file: design/csf_fail_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "csf_consts.svh"
module csf_fail_monitor #(
    parameter int unsigned TIMEOUT = `CSF_FAIL_TIMEOUT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic src_tick,
    output logic fail_pulse
);
    localparam int unsigned CW = $clog2(TIMEOUT + 1);

    if (TIMEOUT < 2) begin : g_chk
        $error("csf_fail_monitor: TIMEOUT must be at least 2");
    end

    logic [CW-1:0] cnt_q;
    logic tripped_q;

    // Counts cycles without source activity; one pulse per loss
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            tripped_q <= 1'b0;
            fail_pulse <= 1'b0;
        end else if (ce) begin
            fail_pulse <= 1'b0;
            if (!enable || src_tick) begin
                cnt_q <= '0;
                tripped_q <= 1'b0;
            end else if (!tripped_q) begin
                if (cnt_q == CW'(TIMEOUT - 1)) begin // [RL9]
                    fail_pulse <= 1'b1;
                    tripped_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    AST_FAIL_TIMEOUT: assert property (@(posedge aclk) disable iff (!aresetn) // [RL9]
        ce && enable && !src_tick && !tripped_q && cnt_q == CW'(TIMEOUT - 1) |=> fail_pulse && tripped_q)
        else $error("Monitor did not flag a lost clock at the timeout");
endmodule
`default_nettype wire

// file: design/csf_pkg.sv
`default_nettype none
package csf_pkg;
    typedef logic [2:0] csf_src_t;
    typedef enum logic {CSF_SW_IDLE, CSF_SW_SETTLE} csf_sw_state_t;
    typedef enum logic [1:0] {CSF_UL_LOCKED, CSF_UL_KEY1, CSF_UL_ARMED} csf_unlock_t;
    typedef enum logic [2:0] {CSF_REG_NONE, CSF_REG_CTRL, CSF_REG_UNLOCK, CSF_REG_STATUS, CSF_REG_MASK} csf_reg_t;
endpackage
`default_nettype wire

// file: design/csf_switch_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "csf_consts.svh"
module csf_switch_seq #(
    parameter int unsigned SETTLE = `CSF_SETTLE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic [2:0] target,
    input wire logic abort,
    output logic busy,
    output logic done_pulse,
    output logic [2:0] cur_src
);
    localparam int unsigned CW = $clog2(SETTLE + 1);

    if (SETTLE < 1) begin : g_chk
        $error("csf_switch_seq: SETTLE must be at least 1");
    end

    csf_pkg::csf_sw_state_t state_q;
    logic [CW-1:0] cnt_q;
    csf_pkg::csf_src_t target_q;

    assign busy = (state_q == csf_pkg::CSF_SW_SETTLE);

    // Switch sequence; a clock failure falls back to the RC source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= csf_pkg::CSF_SW_IDLE;
            cnt_q <= '0;
            target_q <= `CSF_SRC_RC;
            cur_src <= `CSF_SRC_RC;
            done_pulse <= 1'b0;
        end else if (ce) begin
            done_pulse <= 1'b0;
            if (abort) begin
                state_q <= csf_pkg::CSF_SW_IDLE;
                cur_src <= `CSF_SRC_RC;
            end else begin
                case (state_q)
                    csf_pkg::CSF_SW_IDLE: begin
                        if (start) begin // [RL4]
                            target_q <= target;
                            cnt_q <= '0;
                            state_q <= csf_pkg::CSF_SW_SETTLE;
                        end
                    end
                    csf_pkg::CSF_SW_SETTLE: begin
                        if (cnt_q == CW'(SETTLE - 1)) begin // [RL5]
                            cur_src <= target_q;
                            done_pulse <= 1'b1;
                            state_q <= csf_pkg::CSF_SW_IDLE;
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    default: state_q <= csf_pkg::CSF_SW_IDLE;
                endcase
            end
        end
    end

    AST_SWITCH_LOAD: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
        ce && start && !abort && !busy |=> busy && target_q == $past(target))
        else $error("Switch request did not load the selected source");

    AST_SWITCH_DONE: assert property (@(posedge aclk) disable iff (!aresetn) // [RL5]
        ce && busy && !abort && cnt_q == CW'(SETTLE - 1) |=> done_pulse && !busy && cur_src == $past(target_q))
        else $error("Switch did not complete after the settle time");
endmodule
`default_nettype wire

// file: sim/test_csf_clock_switch.sv
`timescale 1ns/10ps
`default_nettype none
`include "csf_consts.svh"
module test_csf_clock_switch;
    localparam int unsigned FT = 4;
    localparam int unsigned ST = 2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic osc_tick = 1'b0;
    logic tick_on = 1'b0;
    logic monitor_enable = 1'b0;
    logic [2:0] source_select;
    logic switch_active;
    logic osc_fail_trap;
    logic irq;
    logic [1:0] resp;
    logic [31:0] rdv;
    int error_cnt = 0;
    int check_count = 0;

    csf_clock_switch #(.ADDR_W(8), .FAIL_TIMEOUT(FT), .SETTLE(ST)) DUT (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .osc_tick(osc_tick), .monitor_enable(monitor_enable), .source_select(source_select),
        .switch_active(switch_active), .osc_fail_trap(osc_fail_trap), .irq(irq)
    );

    always #5 aclk = ~aclk;

    // Oscillator activity, one tick every other cycle while enabled
    always @(posedge aclk) begin
        osc_tick <= tick_on & ~osc_tick;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'b0;
                n = 1000;
            end
        end
        if (n != 1000) begin
            check("write response", 32'h0, 32'h1);
        end
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 100) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid && rready) begin
                rdv = rdata;
                resp = rresp;
                rready <= 1'b0;
                n = 1000;
            end
        end
        if (n != 1000) begin
            check("read response", 32'h0, 32'h1);
        end
        @(posedge aclk);
    endtask

    task automatic do_unlock();
        axi_write(`CSF_OFF_UNLOCK, {16'h0, `CSF_KEY1});
        axi_write(`CSF_OFF_UNLOCK, {16'h0, `CSF_KEY2});
    endtask

    function automatic logic [31:0] ctl(input logic [2:0] cur, input logic [2:0] nxt, input logic cf);
        return {16'h0, 1'b0, cur, 1'b0, nxt, 4'h0, cf, 3'h0};
    endfunction

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        results();
    end

    initial begin
        logic [2:0] tgt [3];
        int n;
        tgt = '{3'h3, `CSF_SRC_RC, 3'h1}; // Always pass through plain RC
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values and unmapped space
        axi_read(`CSF_OFF_CTRL);
        check("ctrl reset", rdv, 32'h0);
        axi_read(`CSF_OFF_STATUS);
        check("status reset", rdv, 32'h0);
        axi_read(`CSF_OFF_MASK);
        check("mask reset", rdv, 32'h0);
        check("trap reset", {31'h0, osc_fail_trap}, 32'h0);
        axi_read(8'h10);
        check("unmapped read", {rdv[31:2], resp}, {30'h0, `CSF_RESP_SLVERR});
        axi_write(8'h10, 32'h0000ffff);
        check("unmapped write", {30'h0, resp}, {30'h0, `CSF_RESP_SLVERR});
        $display("test reset done");
        // Switch through each target with done interrupt
        axi_write(`CSF_OFF_MASK, 32'h1);
        for (int i = 0; i < 3; i++) begin
            do_unlock();
            axi_read(`CSF_OFF_UNLOCK);
            check("unlock armed", rdv, 32'h1);
            axi_write(`CSF_OFF_CTRL, {21'h0, tgt[i], 8'h01});
            check("switch active", {31'h0, switch_active}, 32'h1);
            n = 0;
            rdv = 32'h1;
            while (rdv[0] === 1'b1 && n < 50) begin
                axi_read(`CSF_OFF_CTRL);
                n++;
            end
            check("ctrl after switch", rdv, ctl(tgt[i], tgt[i], 1'b0));
            check("source select", {29'h0, source_select}, {29'h0, tgt[i]});
            check("irq switch done", {31'h0, irq}, 32'h1);
            axi_write(`CSF_OFF_STATUS, 32'h1);
            check("irq cleared", {31'h0, irq}, 32'h0);
        end
        $display("test switch done");
        // Write without unlock is ignored
        axi_write(`CSF_OFF_CTRL, 32'h00000501);
        check("locked resp", {30'h0, resp}, {30'h0, `CSF_RESP_OKAY});
        axi_read(`CSF_OFF_CTRL);
        check("locked ctrl", rdv, ctl(3'h1, 3'h1, 1'b0));
        axi_read(`CSF_OFF_UNLOCK);
        check("unlock consumed", rdv, 32'h0);
        check("locked source", {29'h0, source_select}, 32'h1);
        $display("test locked done");
        // Unimplemented bits
        do_unlock();
        axi_write(`CSF_OFF_CTRL, 32'h00000316);
        axi_read(`CSF_OFF_CTRL);
        check("unimplemented bits", rdv, ctl(3'h1, 3'h3, 1'b0));
        $display("test bits done");
        // Software-set fail flag acts as a real failure
        axi_write(`CSF_OFF_MASK, 32'h0);
        do_unlock();
        axi_write(`CSF_OFF_CTRL, 32'h00000308); // Deliberate one written to the flag
        check("soft trap", {31'h0, osc_fail_trap}, 32'h1);
        check("soft fail source", {29'h0, source_select}, 32'h0);
        axi_read(`CSF_OFF_CTRL);
        check("soft fail ctrl", rdv, ctl(3'h0, 3'h3, 1'b1));
        axi_read(`CSF_OFF_STATUS);
        check("soft fail status", rdv, 32'h2);
        check("irq masked", {31'h0, irq}, 32'h0);
        axi_write(`CSF_OFF_MASK, 32'h3);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        axi_write(`CSF_OFF_STATUS, 32'h2);
        check("irq after clear", {31'h0, irq}, 32'h0);
        do_unlock();
        axi_write(`CSF_OFF_CTRL, 32'h00000300); // Clearing write
        check("trap cleared", {31'h0, osc_fail_trap}, 32'h0);
        axi_read(`CSF_OFF_CTRL);
        check("ctrl cleared", rdv, ctl(3'h0, 3'h3, 1'b0));
        $display("test soft fail done");
        // Monitor detects a stopped oscillator
        tick_on <= 1'b1;
        monitor_enable <= 1'b1;
        repeat (20) @(posedge aclk);
        check("no false fail", {31'h0, osc_fail_trap}, 32'h0);
        // Frozen block ignores the stopped oscillator
        ce <= 1'b0;
        tick_on <= 1'b0;
        repeat (FT + 4) @(posedge aclk);
        check("frozen monitor", {31'h0, osc_fail_trap}, 32'h0);
        ce <= 1'b1;
        repeat (FT + 4) @(posedge aclk);
        check("monitor trap", {31'h0, osc_fail_trap}, 32'h1);
        check("monitor irq", {31'h0, irq}, 32'h1);
        axi_read(`CSF_OFF_CTRL);
        check("monitor ctrl", rdv, ctl(3'h0, 3'h3, 1'b1));
        axi_read(`CSF_OFF_STATUS);
        check("monitor status", rdv, 32'h2);
        tick_on <= 1'b1;
        $display("test monitor done");
        // Reset in mid-run returns every output to idle
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("reset trap", {31'h0, osc_fail_trap}, 32'h0);
        check("reset outputs", {26'h0, irq, switch_active, 1'b0, source_select}, 32'h0);
        axi_read(`CSF_OFF_CTRL);
        check("reset ctrl again", rdv, 32'h0);
        $display("test reset again done");
        results();
    end
endmodule
`default_nettype wire
